// [rtl/antsup_top.sv]
/*
 Antenna supervisor: samples antenna-good and presence inputs, drives the
 supply-off output, reports status and change events over APB.
 Assumes pin inputs asynchronous to pclk; pads carry internal pull-ups.
*/
// The address map and register access over APB are this design's own decisions.
`default_nettype none
module antsup_top
    import antsup_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Antenna pins
    input wire logic antenna_good_in,
    input wire logic antenna_present_in,
    output logic antenna_supply_off_out,
    // Pad pull-up enables
    output logic antenna_good_pu_en,
    output logic antenna_present_pu_en,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [1:0] good_sync_r;                 // Antenna-good synchroniser
    logic [1:0] pres_sync_r;                 // Presence synchroniser
    logic shorted_r;                         // Filtered short state
    logic present_r;                         // Filtered presence state
    logic three_pin_r;                       // Permanent mode latch
    logic [1:0] ctrl_r;                      // Control register
    logic [ANTSUP_EV_W-1:0] ev_r;            // Sticky events
    logic [ANTSUP_EV_W-1:0] mask_r;          // Interrupt mask
    logic [ANTSUP_EV_W-1:0] ev_set;          // Change events this cycle
    logic shorted_nxt;                       // Next short state
    logic present_nxt;                       // Next presence state
    logic supply_off_nxt;                    // Next supply-off level
    logic wr_acc;                            // APB write access phase
    logic rd_acc;                            // APB read access phase
    logic addr_ok;                           // Address is mapped
    logic [31:0] rd_nxt;                     // Read mux
    antsup_status_t stat;                    // Live status record

    assign wr_acc = psel && penable && pwrite && !pready;
    assign rd_acc = psel && penable && !pwrite && !pready;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers (second stage only is used)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            good_sync_r <= 2'h3;
            pres_sync_r <= 2'h3;
        end
        else if (clk_en)
        begin
            good_sync_r <= {good_sync_r[0], antenna_good_in};
            pres_sync_r <= {pres_sync_r[0], antenna_present_in};
        end
    end

    // Decode pin meaning; presence reads connected in two-pin mode
    always_comb
    begin
        shorted_nxt = !good_sync_r[1];
        present_nxt = three_pin_r ? pres_sync_r[1] : 1'b1;
        ev_set = '0;
        ev_set[ANTSUP_EV_SHORT_BIT] = shorted_nxt != shorted_r;
        ev_set[ANTSUP_EV_PRES_BIT] = present_nxt != present_r;
    end

    // Status state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shorted_r <= 1'b0;
            present_r <= 1'b1;
        end
        else if (clk_en)
        begin
            shorted_r <= shorted_nxt;
            present_r <= present_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One-time mode latch: set by keyed write, never cleared but by reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            three_pin_r <= 1'b0;
        end
        else if (clk_en && wr_acc && paddr == ANTSUP_MODE_OFS && pwdata == ANTSUP_MODE_KEY)
        begin
            three_pin_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Supply control: high removes supply in both modes
    always_comb
    begin
        supply_off_nxt = shorted_nxt
            || ctrl_r[ANTSUP_CTRL_SAVE_BIT]
            || ctrl_r[ANTSUP_CTRL_FORCE_OFF_BIT];
    end

    // Output flop; starts off until first healthy sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            antenna_supply_off_out <= 1'b1;
        end
        else if (clk_en)
        begin
            antenna_supply_off_out <= supply_off_nxt;
        end
    end

    // Pad pull-ups always on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            antenna_good_pu_en <= 1'b1;
            antenna_present_pu_en <= 1'b1;
        end
        else if (clk_en)
        begin
            antenna_good_pu_en <= 1'b1;
            antenna_present_pu_en <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and mask registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= ANTSUP_CTRL_RST;
            mask_r <= ANTSUP_MASK_RST;
        end
        else if (clk_en && wr_acc)
        begin
            if (paddr == ANTSUP_CTRL_OFS)
            begin
                ctrl_r <= pwdata[1:0];
            end
            else if (paddr == ANTSUP_MASK_OFS)
            begin
                mask_r <= pwdata[ANTSUP_EV_W-1:0];
            end
        end
    end

    // Sticky events: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_r <= '0;
        end
        else if (clk_en)
        begin
            if (wr_acc && paddr == ANTSUP_IRQ_OFS)
            begin
                ev_r <= (ev_r & ~pwdata[ANTSUP_EV_W-1:0]) | ev_set;
            end
            else
            begin
                ev_r <= ev_r | ev_set;
            end
        end
    end

    // Interrupt level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            irq <= |(ev_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read mux
    assign stat = '{three_pin: three_pin_r, supply_off: antenna_supply_off_out,
                    present: present_r, shorted: shorted_r};

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        addr_ok = 1'b1;
        if (paddr == ANTSUP_CTRL_OFS)
        begin
            rd_nxt[1:0] = ctrl_r;
        end
        else if (paddr == ANTSUP_STAT_OFS)
        begin
            rd_nxt[3:0] = stat;
        end
        else if (paddr == ANTSUP_IRQ_OFS)
        begin
            rd_nxt[ANTSUP_EV_W-1:0] = ev_r;
        end
        else if (paddr == ANTSUP_MASK_OFS)
        begin
            rd_nxt[ANTSUP_EV_W-1:0] = mask_r;
        end
        else if (paddr == ANTSUP_MODE_OFS)
        begin
            rd_nxt[0] = three_pin_r;
        end
        else if (paddr == ANTSUP_MON_OFS)
        begin
            rd_nxt = {24'h00_0000, 2'h0, ev_r, stat};
        end
        else
        begin
            addr_ok = 1'b0;
        end
    end

    // APB answer: one wait cycle, pready and data from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
            prdata <= rd_acc ? rd_nxt : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_reset_two_pin;
        @(posedge pclk) $rose(presetn) |-> !three_pin_r;
    endproperty
    a_reset_two_pin: assert property (p_reset_two_pin) else $error("Mode not two-pin after reset");

    property p_short_off;
        @(posedge pclk) disable iff (!presetn) clk_en && shorted_nxt |=> antenna_supply_off_out;
    endproperty
    a_short_off: assert property (p_short_off) else $error("Supply not removed on short");

    property p_save_off;
        @(posedge pclk) disable iff (!presetn) clk_en && ctrl_r[ANTSUP_CTRL_SAVE_BIT] |=> antenna_supply_off_out;
    endproperty
    a_save_off: assert property (p_save_off) else $error("Supply not removed in power save");

    // Sampled presetn keeps the release edge out: the output leaves reset one edge later
    property p_on_when_ok;
        @(posedge pclk) disable iff (!presetn)
            presetn && clk_en && good_sync_r[1] && ctrl_r == 2'h0 |=> !antenna_supply_off_out;
    endproperty
    a_on_when_ok: assert property (p_on_when_ok) else $error("Supply not on for healthy antenna");

    property p_good_decode;
        @(posedge pclk) disable iff (!presetn) clk_en |=> shorted_r == !$past(good_sync_r[1]);
    endproperty
    a_good_decode: assert property (p_good_decode) else $error("Short state mismatches input");

    property p_pres_decode;
        @(posedge pclk) disable iff (!presetn)
            clk_en && three_pin_r && !pres_sync_r[1] |=> !present_r;
    endproperty
    a_pres_decode: assert property (p_pres_decode) else $error("Absent antenna not reported");

    property p_mode_sticky;
        @(posedge pclk) disable iff (!presetn) three_pin_r |=> three_pin_r;
    endproperty
    a_mode_sticky: assert property (p_mode_sticky) else $error("Three-pin mode lost");

    sequence s_change;
        clk_en && ev_set[ANTSUP_EV_SHORT_BIT];
    endsequence
    property p_event_flag;
        @(posedge pclk) disable iff (!presetn) s_change |=> ev_r[ANTSUP_EV_SHORT_BIT];
    endproperty
    a_event_flag: assert property (p_event_flag) else $error("Short change not flagged");

    property p_pullup;
        @(posedge pclk) disable iff (!presetn) antenna_good_pu_en && antenna_present_pu_en;
    endproperty
    a_pullup: assert property (p_pullup) else $error("Pull-up disabled");

endmodule : antsup_top
`default_nettype wire

// [pkg/antsup_pkg.sv]
/*
 Package for the antenna supervisor: register offsets, field positions,
 reset values and the status record carried between processes.
 Assumes a 32-bit APB slave with word-aligned registers.
*/
`default_nettype none
package antsup_pkg;
    // Register byte offsets
    localparam logic [11:0] ANTSUP_CTRL_OFS = 12'h000;   // Control
    localparam logic [11:0] ANTSUP_STAT_OFS = 12'h004;   // Live status
    localparam logic [11:0] ANTSUP_IRQ_OFS = 12'h008;    // Sticky events, write one to clear
    localparam logic [11:0] ANTSUP_MASK_OFS = 12'h00c;   // Interrupt mask
    localparam logic [11:0] ANTSUP_MODE_OFS = 12'h010;   // One-time mode latch
    localparam logic [11:0] ANTSUP_MON_OFS = 12'h014;    // Hardware monitor message word
    // Control fields
    localparam int ANTSUP_CTRL_SAVE_BIT = 0;             // Power-save request
    localparam int ANTSUP_CTRL_FORCE_OFF_BIT = 1;        // Software forced supply off
    // Event fields
    localparam int ANTSUP_EV_SHORT_BIT = 0;              // Short state changed
    localparam int ANTSUP_EV_PRES_BIT = 1;               // Presence state changed
    localparam int ANTSUP_EV_W = 2;                      // Number of events
    // Mode latch key that must accompany the one-time write
    localparam logic [31:0] ANTSUP_MODE_KEY = 32'h3a4e_0001;
    // Reset values
    localparam logic [1:0] ANTSUP_CTRL_RST = 2'h0;
    localparam logic [1:0] ANTSUP_MASK_RST = 2'h0;
    // Live antenna status record
    typedef struct packed {
        logic three_pin;   // Three-pin mode active
        logic supply_off;  // Supply control output level
        logic present;     // Antenna connected
        logic shorted;     // Short detected
    } antsup_status_t;
endpackage : antsup_pkg
`default_nettype wire

// [dv/antsup_ant_model.sv]
/*
 Model of the external active-antenna supply and detection circuit.
 Assumes the bench commands a short or an absent antenna.
*/
`default_nettype none
module antsup_ant_model (
    // Commands from the bench
    input wire logic short_cmd,
    input wire logic absent_cmd,
    // Lines into the supervisor
    output logic good,
    output logic present
);
    timeunit 1ns;
    timeprecision 1ps;
    // A short pulls the good line low
    assign good = !short_cmd;
    // Detection line stays high while an antenna is connected
    assign present = !absent_cmd;
endmodule : antsup_ant_model
`default_nettype wire

// [dv/tb_antsup_top.sv]
/*
 Self-checking bench for the antenna supervisor.
 Assumes one wait state on APB and a three-edge input path.
*/
`default_nettype none
module tb_antsup_top
    import antsup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic good;
    logic present;
    logic soff;
    logic gpu;
    logic ppu;
    logic irq;
    logic short_cmd = 1'b0;
    logic absent_cmd = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] rd;
    logic rerr;
    int err_count = 0;
    int checks = 0;

    ////////////////////////////////////////////////////////////////
    // Clock and instances
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    antsup_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .antenna_good_in(good), .antenna_present_in(present),
        .antenna_supply_off_out(soff), .antenna_good_pu_en(gpu), .antenna_present_pu_en(ppu), .irq(irq));
    antsup_ant_model ant (.short_cmd(short_cmd), .absent_cmd(absent_cmd), .good(good), .present(present));

    ////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic tally_and_finish();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            err_count++;
            tally_and_finish();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Bounded wait for the supply line to reach a level
    task automatic wait_off(input logic lvl);
        int n;
        for (n = 0; n < 10 && soff !== lvl; n++)
            @(posedge pclk);
        chk(32'(soff), 32'(lvl));
        // A wait that ran out ends the run
        if (soff !== lvl)
            tally_and_finish();
    endtask : wait_off

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_short();
        apb(1'b1, ANTSUP_MASK_OFS, 32'h1);
        short_cmd <= 1'b1;
        wait_off(1'b1);
        apb(1'b0, ANTSUP_STAT_OFS, 32'h0);
        chk(rd, 32'h7);
        chk(32'(irq), 32'h1);
        apb(1'b1, ANTSUP_MASK_OFS, 32'h0);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0);
        short_cmd <= 1'b0;
        wait_off(1'b0);
        apb(1'b1, ANTSUP_IRQ_OFS, 32'h3);
        apb(1'b0, ANTSUP_IRQ_OFS, 32'h0);
        chk(rd, 32'h0);
        $display("short test done");
    endtask : t_short
    task automatic t_save();
        apb(1'b1, ANTSUP_CTRL_OFS, 32'h1);
        wait_off(1'b1);
        apb(1'b0, ANTSUP_MON_OFS, 32'h0);
        chk(rd, 32'h6);
        apb(1'b1, ANTSUP_CTRL_OFS, 32'h0);
        wait_off(1'b0);
        apb(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], rerr}, 32'h1);
        $display("save test done");
    endtask : t_save
    task automatic t_mode();
        apb(1'b0, ANTSUP_MODE_OFS, 32'h0);
        chk(rd, 32'h0);
        absent_cmd <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, ANTSUP_STAT_OFS, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, ANTSUP_MODE_OFS, 32'h1);
        apb(1'b0, ANTSUP_MODE_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, ANTSUP_MODE_OFS, ANTSUP_MODE_KEY);
        repeat (4) @(posedge pclk);
        apb(1'b0, ANTSUP_STAT_OFS, 32'h0);
        chk(rd, 32'h8);
        apb(1'b0, ANTSUP_IRQ_OFS, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, ANTSUP_MODE_OFS, 32'h0);
        apb(1'b0, ANTSUP_MODE_OFS, 32'h0);
        chk(rd, 32'h1);
        short_cmd <= 1'b1;
        wait_off(1'b1);
        $display("mode test done");
    endtask : t_mode
    // Clock enable low: a cleared short must not reach the output
    task automatic t_freeze();
        clk_en <= 1'b0;
        short_cmd <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'(soff), 32'h1);
        clk_en <= 1'b1;
        wait_off(1'b0);
        $display("freeze test done");
    endtask : t_freeze
    // Mid-run reset: supply off while held, two-pin mode after release
    task automatic t_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(soff), 32'h1);
        presetn <= 1'b1;
        apb(1'b0, ANTSUP_MODE_OFS, 32'h0);
        chk(rd, 32'h0);
        wait_off(1'b0);
        $display("reset test done");
    endtask : t_reset

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (20) @(posedge pclk);
        chk(32'(soff), 32'h1);
        chk({30'h0, gpu, ppu}, 32'h3);
        presetn <= 1'b1;
        wait_off(1'b0);
        t_short();
        t_save();
        t_mode();
        t_freeze();
        t_reset();
        tally_and_finish();
    end
endmodule : tb_antsup_top
`default_nettype wire
